// ### hw/etw_params.svh
// Timing counts, map layout and codes for the emulator bus wait logic
`ifndef ETW_PARAMS_SVH
`define ETW_PARAMS_SVH
`define ETW_CLK_MHZ        250
`define ETW_AW             16
`define ETW_DW             16
`define ETW_PAGE_MSB       15
`define ETW_PAGE_LSB       12
`define ETW_FAST_AW        12
`define ETW_FAST_PAGE      4'h0
`define ETW_DYN_AW         12
`define ETW_DYN_LAT        3'h2
`define ETW_CMD_CYCLES     4'h8
`define ETW_SYNC_TIME_NS   4000
`define ETW_SYNC_CYCLES    ((`ETW_SYNC_TIME_NS * `ETW_CLK_MHZ) / 1000)
`define ETW_ERR_SYNC_LOST  16'h0488
`define ETW_MHZ_SLOW       8'h14
`define ETW_MHZ_FAST       8'h28
`define ETW_TGT_AW         8
`define ETW_TGT_WAITS      2'h2
`define ETW_TGT_SLOW_BIT   15
`define ETW_TGT_REFRESH    3'h4
`define ETW_BUS_IDLE_WORD  16'hffff
`endif

// ### hw/etw_pkg.sv
// Types used by the emulator end and the testbench of the emulator bus wait logic
package etw_pkg;
  typedef enum logic [1:0] {
    ETW_SP_PROG = 2'h0,
    ETW_SP_DATA = 2'h1,
    ETW_SP_IO   = 2'h2
  } etw_space_t;

  typedef enum logic [1:0] {
    ETW_RT_TGT  = 2'h0,
    ETW_RT_FAST = 2'h1,
    ETW_RT_DYN  = 2'h2
  } etw_route_t;

  typedef enum logic [2:0] {
    ETW_ST_IDLE  = 3'h0,
    ETW_ST_ADDR  = 3'h1,
    ETW_ST_BUS_STROBE_N  = 3'h3,
    ETW_ST_DWAIT = 3'h2,
    ETW_ST_DDRV  = 3'h6
  } etw_state_t;

  typedef enum logic [1:0] {
    ETW_CS_CABLE    = 2'h0,
    ETW_CS_CRYSTAL  = 2'h1,
    ETW_CS_OSC      = 2'h2,
    ETW_CS_TGT_XTAL = 2'h3
  } etw_clk_src_t;
endpackage : etw_pkg

// ### hw/etw_bus_if.sv
// Target connector between the emulated processor and the target logic
`include "etw_params.svh"
interface etw_bus_if;
  logic [`ETW_AW-1:0] addr;
  logic               rw;
  logic               data_space_select_n;
  logic               program_space_select_n;
  logic               io_space_select_n;
  logic               bus_strobe_n;
  logic               ready;
  logic               hold_n;
  logic               bus_grant_n;
  logic               processor_reset_n;
  logic [`ETW_DW-1:0] emu_d_out;
  logic               emu_d_oe;
  logic [`ETW_DW-1:0] tgt_d_out;
  logic               tgt_d_oe;
  logic [`ETW_DW-1:0] data_bus;
  logic               bus_clash;

  // Pull-ups hold the bus high when nobody drives it
  assign data_bus  = emu_d_oe ? emu_d_out
                   : (tgt_d_oe ? tgt_d_out : `ETW_BUS_IDLE_WORD);
  assign bus_clash = emu_d_oe & tgt_d_oe;

  modport emu (
    output addr, rw, data_space_select_n, program_space_select_n,
    output io_space_select_n, bus_strobe_n, bus_grant_n,
    output emu_d_out, emu_d_oe,
    input  ready, hold_n, processor_reset_n, data_bus
  );
  modport tgt (
    input  addr, rw, data_space_select_n, program_space_select_n,
    input  io_space_select_n, bus_strobe_n, bus_grant_n, data_bus,
    output ready, hold_n, processor_reset_n, tgt_d_out, tgt_d_oe
  );
endinterface : etw_bus_if

// ### hw/etw_emu_end.sv
// Emulator end: processor bus cycles, substitution memories, hold interlock
`include "etw_params.svh"
module etw_emu_end (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  etw_bus_if.emu                    bus,
  input  wire logic                 acc_req,
  input  wire etw_pkg::etw_space_t  acc_space,
  input  wire logic [`ETW_AW-1:0]   acc_addr,
  input  wire logic                 acc_wr,
  input  wire logic [`ETW_DW-1:0]   acc_wdata,
  output logic                      acc_ready,
  output logic                      acc_done,
  output logic [`ETW_DW-1:0]        acc_rdata,
  input  wire logic                 cfg_load,
  input  wire logic                 cfg_fast_prog,
  input  wire logic                 cfg_fast_data,
  input  wire logic                 cfg_dyn_en,
  input  wire logic [3:0]           cfg_dyn_page,
  input  wire logic                 cmd_req,
  input  wire logic [`ETW_DW-1:0]   cmd_word,
  output logic                      cmd_busy,
  output logic                      cmd_done,
  output logic                      halt_irq,
  output logic                      run_mode,
  output logic                      sync_err,
  output logic [15:0]               err_code,
  output logic [31:0]               cycle_count,
  input  wire etw_pkg::etw_clk_src_t clk_src,
  input  wire logic                 clk_variant_fast,
  input  wire logic [7:0]           clk_src_mhz,
  output logic                      clk_cfg_ok
);
  localparam int SYNC_N = `ETW_SYNC_CYCLES;

  etw_pkg::etw_state_t st_ff;
  etw_pkg::etw_space_t space_ff;
  etw_pkg::etw_route_t route_ff;
  etw_pkg::etw_route_t nxt_route;
  logic [`ETW_AW-1:0]  addr_ff;
  logic                wr_ff;
  logic [`ETW_DW-1:0]  dout_ff;
  logic [2:0]          lat_ff;
  logic                fast_prog_ff;
  logic                fast_data_ff;
  logic                dyn_en_ff;
  logic [3:0]          dyn_page_ff;
  logic                grant_ff;
  logic                pend_ff;
  logic                lock_ff;
  logic [3:0]          cmd_cnt_ff;
  logic [15:0]         sync_cnt_ff;
  logic                sel_on;
  logic                blocked;
  logic                start;
  logic                all_high;

  logic [`ETW_DW-1:0]  fast_mem [0:(2**(`ETW_FAST_AW+1))-1];
  logic [`ETW_DW-1:0]  dyn_mem  [0:(2**`ETW_DYN_AW)-1];

  // Mapping decode of a new request
  always_comb
  begin
    nxt_route = etw_pkg::ETW_RT_TGT;
    if (acc_addr[`ETW_PAGE_MSB:`ETW_PAGE_LSB] == `ETW_FAST_PAGE &&
        ((acc_space == etw_pkg::ETW_SP_PROG && fast_prog_ff) ||
         (acc_space == etw_pkg::ETW_SP_DATA && fast_data_ff)))
      nxt_route = etw_pkg::ETW_RT_FAST;
    else if (dyn_en_ff && acc_space != etw_pkg::ETW_SP_IO &&
             acc_addr[`ETW_PAGE_MSB:`ETW_PAGE_LSB] == dyn_page_ff)
      nxt_route = etw_pkg::ETW_RT_DYN;
  end

  // Processor may not start a cycle while the target owns or resets the bus
  assign acc_ready = st_ff == etw_pkg::ETW_ST_IDLE && !grant_ff &&
                     !lock_ff && bus.processor_reset_n;
  assign start     = acc_req && acc_ready;

  // Controls are active only in address and strobe phases
  assign sel_on = st_ff == etw_pkg::ETW_ST_ADDR ||
                  st_ff == etw_pkg::ETW_ST_BUS_STROBE_N;
  assign bus.addr = addr_ff;
  assign bus.rw   = !wr_ff;
  assign bus.data_space_select_n =
    !(sel_on && space_ff == etw_pkg::ETW_SP_DATA);
  assign bus.program_space_select_n =
    !(sel_on && space_ff == etw_pkg::ETW_SP_PROG);
  assign bus.io_space_select_n =
    !(sel_on && space_ff == etw_pkg::ETW_SP_IO);
  assign bus.bus_strobe_n = st_ff != etw_pkg::ETW_ST_BUS_STROBE_N;
  assign bus.bus_grant_n  = !grant_ff;
  assign bus.emu_d_out    = dout_ff;

  assign all_high = bus.data_space_select_n && bus.program_space_select_n &&
                    bus.io_space_select_n && bus.bus_grant_n &&
                    bus.bus_strobe_n;
  // Target writes drive the bus; fast and dynamic writes stay internal
  always_comb
  begin
    bus.emu_d_oe = 1'b0;
    if (st_ff == etw_pkg::ETW_ST_BUS_STROBE_N && wr_ff &&
        route_ff == etw_pkg::ETW_RT_TGT)
      bus.emu_d_oe = 1'b1;
    else if (st_ff == etw_pkg::ETW_ST_DDRV && all_high)
      bus.emu_d_oe = 1'b1;
    else if (cmd_busy && all_high)
      bus.emu_d_oe = 1'b1;
  end

  // Substitution map; cleared at power-up so the target sees plain cycles
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      fast_prog_ff <= 1'b0;
      fast_data_ff <= 1'b0;
      dyn_en_ff    <= 1'b0;
      dyn_page_ff  <= 4'h0;
    end
    else if (cfg_load && st_ff == etw_pkg::ETW_ST_IDLE)
    begin
      fast_prog_ff <= cfg_fast_prog;
      fast_data_ff <= cfg_fast_data;
      dyn_en_ff    <= cfg_dyn_en;
      dyn_page_ff  <= cfg_dyn_page;
    end
  end

  // Bus cycle sequencer
  always_ff @(posedge clk)
  begin
    acc_done <= 1'b0;
    if (!nrst || !bus.processor_reset_n)
    begin
      st_ff    <= etw_pkg::ETW_ST_IDLE;
      space_ff <= etw_pkg::ETW_SP_PROG;
      route_ff <= etw_pkg::ETW_RT_TGT;
      addr_ff  <= '0;
      wr_ff    <= 1'b0;
      lat_ff   <= 3'h0;
      acc_done <= 1'b0;
    end
    else
    begin
      unique case (st_ff)
        etw_pkg::ETW_ST_IDLE:
          if (start)
          begin
            st_ff    <= etw_pkg::ETW_ST_ADDR;
            space_ff <= acc_space;
            route_ff <= nxt_route;
            addr_ff  <= acc_addr;
            wr_ff    <= acc_wr;
          end
        etw_pkg::ETW_ST_ADDR:
          st_ff <= etw_pkg::ETW_ST_BUS_STROBE_N;
        etw_pkg::ETW_ST_BUS_STROBE_N:
          if (bus.ready)
          begin
            lat_ff <= 3'h0;
            if (route_ff == etw_pkg::ETW_RT_DYN)
              st_ff <= etw_pkg::ETW_ST_DWAIT;
            else
            begin
              st_ff    <= etw_pkg::ETW_ST_IDLE;
              acc_done <= 1'b1;
            end
          end
        etw_pkg::ETW_ST_DWAIT:
        begin
          lat_ff <= lat_ff + 3'h1;
          if (lat_ff == `ETW_DYN_LAT - 3'h1)
          begin
            if (wr_ff)
            begin
              st_ff    <= etw_pkg::ETW_ST_IDLE;
              acc_done <= 1'b1;
            end
            else
              st_ff <= etw_pkg::ETW_ST_DDRV;
          end
        end
        etw_pkg::ETW_ST_DDRV:
        begin
          st_ff    <= etw_pkg::ETW_ST_IDLE;
          acc_done <= 1'b1;
        end
        default:
          st_ff <= etw_pkg::ETW_ST_IDLE;
      endcase
    end
  end

  // Memories, data register and read return
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      dout_ff   <= '0;
      acc_rdata <= '0;
    end
    else if (start)
      dout_ff <= acc_wdata;
    else if (pend_ff && !lock_ff && !blocked && acc_ready)
      dout_ff <= cmd_word;
    else if (st_ff == etw_pkg::ETW_ST_BUS_STROBE_N && bus.ready)
    begin
      if (route_ff == etw_pkg::ETW_RT_FAST)
      begin
        if (wr_ff)
          fast_mem[{space_ff == etw_pkg::ETW_SP_DATA,
                    addr_ff[`ETW_FAST_AW-1:0]}] <= dout_ff;
        else
          acc_rdata <= fast_mem[{space_ff == etw_pkg::ETW_SP_DATA,
                                 addr_ff[`ETW_FAST_AW-1:0]}];
      end
      else if (route_ff == etw_pkg::ETW_RT_DYN)
      begin
        if (wr_ff)
          dyn_mem[addr_ff[`ETW_DYN_AW-1:0]] <= dout_ff;
        else
          dout_ff <= dyn_mem[addr_ff[`ETW_DYN_AW-1:0]];
      end
      else if (!wr_ff)
        acc_rdata <= bus.data_bus;
    end
    else if (st_ff == etw_pkg::ETW_ST_DDRV)
      acc_rdata <= dout_ff;
  end

  // Hold grant; the interlock keeps it off while a command runs
  always_ff @(posedge clk)
  begin
    if (!nrst)
      grant_ff <= 1'b0;
    else if (bus.hold_n)
      grant_ff <= 1'b0;
    else if (st_ff == etw_pkg::ETW_ST_IDLE && !lock_ff)
      grant_ff <= 1'b1;
  end

  // Command sequencing with sync-lost watchdog
  assign blocked  = !bus.processor_reset_n || !bus.hold_n || !bus.ready ||
                    grant_ff;
  assign cmd_busy = lock_ff && cmd_cnt_ff != 4'h0;
  always_ff @(posedge clk)
  begin
    halt_irq <= 1'b0;
    cmd_done <= 1'b0;
    sync_err <= 1'b0;
    if (!nrst)
    begin
      pend_ff     <= 1'b0;
      lock_ff     <= 1'b0;
      cmd_cnt_ff  <= 4'h0;
      sync_cnt_ff <= 16'h0000;
      run_mode    <= 1'b1;
      err_code    <= 16'h0000;
    end
    else
    begin
      if (cmd_req && !pend_ff)
        pend_ff <= 1'b1;
      if (pend_ff && !lock_ff)
      begin
        if (!blocked && acc_ready)
        begin
          lock_ff     <= 1'b1;
          cmd_cnt_ff  <= `ETW_CMD_CYCLES;
          halt_irq    <= 1'b1;
          run_mode    <= 1'b0;
          sync_cnt_ff <= 16'h0000;
        end
        else if (sync_cnt_ff == 16'(SYNC_N - 1))
        begin
          pend_ff     <= 1'b0;
          sync_err    <= 1'b1;
          err_code    <= `ETW_ERR_SYNC_LOST;
          sync_cnt_ff <= 16'h0000;
        end
        else
          sync_cnt_ff <= sync_cnt_ff + 16'h0001;
      end
      else if (lock_ff)
      begin
        if (cmd_cnt_ff != 4'h0 && all_high)
          cmd_cnt_ff <= cmd_cnt_ff - 4'h1;
        else if (cmd_cnt_ff == 4'h0)
        begin
          lock_ff  <= 1'b0;
          pend_ff  <= 1'b0;
          cmd_done <= 1'b1;
          run_mode <= 1'b1;
        end
      end
    end
  end

  // Every non-idle cycle counts, target waits and internal latency alike
  always_ff @(posedge clk)
  begin
    if (!nrst)
      cycle_count <= 32'h0000_0000;
    else if (st_ff != etw_pkg::ETW_ST_IDLE)
      cycle_count <= cycle_count + 32'h0000_0001;
  end

  // A crystal on the target cannot be buffered through the cable
  always_ff @(posedge clk)
  begin
    if (!nrst)
      clk_cfg_ok <= 1'b0;
    else
      clk_cfg_ok <= clk_src != etw_pkg::ETW_CS_TGT_XTAL &&
                    clk_src_mhz == (clk_variant_fast ? `ETW_MHZ_FAST
                                                     : `ETW_MHZ_SLOW);
  end
endmodule : etw_emu_end

// ### hw/etw_tgt_end.sv
// Target end: ready generator, wait-state memory, hold and reset sources
`include "etw_params.svh"
module etw_tgt_end (
  input  wire logic               clk,
  input  wire logic               nrst,
  etw_bus_if.tgt                  bus,
  input  wire logic               hold_req,
  output logic                    hold_granted,
  input  wire logic               dma_drive,
  input  wire logic [`ETW_DW-1:0] dma_word,
  input  wire logic               proc_reset_req,
  input  wire logic               refresh_req,
  input  wire logic               fast_prog_mapped,
  input  wire logic               fast_data_mapped
);
  logic [1:0]         wcnt_ff;
  logic [2:0]         refresh_ff;
  logic [`ETW_DW-1:0] dout_ff;
  logic               sel_any;
  logic               slow_sel;
  logic               fast_cover;
  logic               own_sel;

  logic [`ETW_DW-1:0] tgt_mem [0:(2**`ETW_TGT_AW)-1];

  // Fast substitution overlays the low page; the target steps aside there
  assign fast_cover =
    bus.addr[`ETW_PAGE_MSB:`ETW_PAGE_LSB] == `ETW_FAST_PAGE &&
    ((!bus.program_space_select_n && fast_prog_mapped) ||
     (!bus.data_space_select_n && fast_data_mapped));
  assign sel_any  = !bus.data_space_select_n ||
                    !bus.program_space_select_n || !bus.io_space_select_n;
  assign own_sel  = sel_any && !fast_cover;
  // Fast substitution needs no waits, so the overlaid page stalls only for refresh
  assign slow_sel = (!bus.data_space_select_n ||
                     !bus.program_space_select_n) &&
                    !bus.addr[`ETW_TGT_SLOW_BIT] && !fast_cover;

  // Pure decode so ready settles early in the cycle
  assign bus.ready = refresh_ff == 3'h0 &&
                     (!slow_sel || wcnt_ff == `ETW_TGT_WAITS);

  // Wait counter always reaches its end, so ready returns high
  always_ff @(posedge clk)
  begin
    if (!nrst || bus.bus_strobe_n)
      wcnt_ff <= 2'h0;
    else if (slow_sel && wcnt_ff != `ETW_TGT_WAITS)
      wcnt_ff <= wcnt_ff + 2'h1;
  end

  // Refresh stretches cycles via ready; hold grant could come too late
  always_ff @(posedge clk)
  begin
    if (!nrst)
      refresh_ff <= 3'h0;
    else if (refresh_req && refresh_ff == 3'h0)
      refresh_ff <= `ETW_TGT_REFRESH;
    else if (refresh_ff != 3'h0)
      refresh_ff <= refresh_ff - 3'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      dout_ff <= '0;
    else if (!bus.bus_grant_n)
      dout_ff <= dma_word;
    else
      dout_ff <= tgt_mem[bus.addr[`ETW_TGT_AW-1:0]];
  end

  always_ff @(posedge clk)
  begin
    if (own_sel && !bus.bus_strobe_n && !bus.rw)
      tgt_mem[bus.addr[`ETW_TGT_AW-1:0]] <= bus.data_bus;
  end

  assign bus.tgt_d_out = dout_ff;
  assign bus.tgt_d_oe  = (!bus.bus_grant_n && dma_drive) ||
                         (own_sel && bus.rw && !bus.bus_strobe_n);
  assign bus.hold_n            = !hold_req;
  assign bus.processor_reset_n = !proc_reset_req;
  assign hold_granted          = !bus.bus_grant_n;
endmodule : etw_tgt_end

// ### testbench/etw_bus_asserts.sv
// Concurrent checks on the target connector between both ends
`include "etw_params.svh"
module etw_bus_asserts (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic [`ETW_AW-1:0] addr,
  input wire logic               rw,
  input wire logic               data_space_select_n,
  input wire logic               program_space_select_n,
  input wire logic               io_space_select_n,
  input wire logic               bus_strobe_n,
  input wire logic               ready,
  input wire logic               hold_n,
  input wire logic               bus_grant_n,
  input wire logic               processor_reset_n,
  input wire logic               emu_d_oe,
  input wire logic               bus_clash
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sel_act;
  logic ctl_idle;
  assign sel_act  = ~(data_space_select_n & program_space_select_n
                    & io_space_select_n);
  assign ctl_idle = ~sel_act & bus_strobe_n & bus_grant_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_open;
    $rose(sel_act) && processor_reset_n;
  endsequence
  sequence s_stall;
    !bus_strobe_n && !ready && processor_reset_n;
  endsequence

  chk_no_clash: assert property (!bus_clash)
    else $error("both ends drive the data bus");
  chk_read_drive_idle: assert property (emu_d_oe && rw |-> ctl_idle)
    else $error("emulator drives read data with a control active");
  chk_oe_no_grant: assert property (emu_d_oe |-> bus_grant_n)
    else $error("grant active while emulator drives the bus");
  chk_grant_cause: assert property
    ($fell(bus_grant_n) |-> !$past(hold_n) && !sel_act)
    else $error("grant without a hold request or during an access");
  chk_grant_release: assert property
    (!bus_grant_n && hold_n |=> bus_grant_n)
    else $error("grant kept after hold was released");
  chk_open_strobe: assert property
    (s_open |-> bus_strobe_n ##1 (!bus_strobe_n || !processor_reset_n))
    else $error("strobe does not follow the select by one cycle");
  chk_wait_stall: assert property (s_stall |=> !bus_strobe_n)
    else $error("strobe ended while ready was low");
  chk_addr_steady: assert property
    ($fell(bus_strobe_n) |-> $stable(addr) && $stable(rw) && sel_act)
    else $error("address or select changed at strobe start");
  chk_drive_gap: assert property
    ($rose(emu_d_oe) && rw |-> $past(bus_strobe_n) && $past(bus_strobe_n, 2))
    else $error("read data driven without an idle clock after strobe");
endmodule : etw_bus_asserts

// ### testbench/emulator_target_bus_wait_logic_tb.sv
// Testbench joining both ends over the target connector
module emulator_target_bus_wait_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic acc_req, acc_wr, acc_ready, acc_done, cfg_load, cfg_fast_prog;
  logic cfg_fast_data, cfg_dyn_en, cmd_req, cmd_busy, cmd_done, halt_irq;
  logic run_mode, sync_err, clk_variant_fast, clk_cfg_ok, hold_req, seen;
  logic hold_granted, dma_drive, proc_reset_req, refresh_req;
  logic fast_prog_mapped, fast_data_mapped;
  logic [15:0] acc_addr, acc_wdata, acc_rdata, cmd_word, err_code, dma_word;
  logic [31:0] cycle_count;
  logic [7:0]  clk_src_mhz;
  logic [3:0]  cfg_dyn_page;
  etw_pkg::etw_space_t   acc_space;
  etw_pkg::etw_clk_src_t clk_src;
  int mismatches = 0;
  int check_count = 0;
  int lt, ls, lf, ld, n;

  etw_bus_if etw_bus_if_inst ();
  etw_emu_end etw_emu_end_inst (.clk, .nrst, .bus(etw_bus_if_inst), .acc_req,
    .acc_space, .acc_addr, .acc_wr, .acc_wdata, .acc_ready, .acc_done,
    .acc_rdata, .cfg_load, .cfg_fast_prog, .cfg_fast_data, .cfg_dyn_en,
    .cfg_dyn_page, .cmd_req, .cmd_word, .cmd_busy, .cmd_done, .halt_irq,
    .run_mode, .sync_err, .err_code, .cycle_count, .clk_src,
    .clk_variant_fast, .clk_src_mhz, .clk_cfg_ok);
  etw_tgt_end etw_tgt_end_inst (.clk, .nrst, .bus(etw_bus_if_inst), .hold_req,
    .hold_granted, .dma_drive, .dma_word, .proc_reset_req, .refresh_req,
    .fast_prog_mapped, .fast_data_mapped);
  etw_bus_asserts etw_bus_asserts_inst (.clk, .nrst,
    .addr(etw_bus_if_inst.addr), .rw(etw_bus_if_inst.rw),
    .data_space_select_n(etw_bus_if_inst.data_space_select_n),
    .program_space_select_n(etw_bus_if_inst.program_space_select_n),
    .io_space_select_n(etw_bus_if_inst.io_space_select_n),
    .bus_strobe_n(etw_bus_if_inst.bus_strobe_n),
    .ready(etw_bus_if_inst.ready), .hold_n(etw_bus_if_inst.hold_n),
    .bus_grant_n(etw_bus_if_inst.bus_grant_n),
    .processor_reset_n(etw_bus_if_inst.processor_reset_n),
    .emu_d_oe(etw_bus_if_inst.emu_d_oe),
    .bus_clash(etw_bus_if_inst.bus_clash));

  always #2 clk = ~clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step

  // Bounded waits so a stuck handshake ends in a mismatch, not a hang
  task automatic acc(input etw_pkg::etw_space_t sp, input logic [15:0] a,
                     input logic wr, input logic [15:0] wd, output int lat);
    int k;
    k = 0;
    while (acc_ready !== 1'b1 && k < 50)
    begin
      step(1);
      k++;
    end
    acc_space = sp;
    acc_addr  = a;
    acc_wr    = wr;
    acc_wdata = wd;
    acc_req   = 1'b1;
    step(1);
    acc_req = 1'b0;
    lat = 1;
    while (acc_done !== 1'b1 && lat < 50)
    begin
      step(1);
      lat++;
    end
    chk(acc_done, 1'b1);
  endtask : acc

  task automatic rd(input etw_pkg::etw_space_t sp, input logic [15:0] a,
                    input logic [15:0] exp, output int lat);
    acc(sp, a, 1'b0, 16'h0000, lat);
    chk(acc_rdata, exp);
  endtask : rd

  task automatic wr(input etw_pkg::etw_space_t sp, input logic [15:0] a,
                    input logic [15:0] d);
    int k;
    acc(sp, a, 1'b1, d, k);
  endtask : wr

  // Target map inputs must mirror the emulator map or both ends collide
  task automatic cfg(input logic fp, input logic fd, input logic de,
                     input logic [3:0] pg);
    cfg_fast_prog    = fp;
    cfg_fast_data    = fd;
    cfg_dyn_en       = de;
    cfg_dyn_page     = pg;
    fast_prog_mapped = fp;
    fast_data_mapped = fd;
    cfg_load         = 1'b1;
    step(1);
    cfg_load = 1'b0;
    step(1);
  endtask : cfg

  task automatic refresh();
    refresh_req = 1'b1;
    step(1);
    refresh_req = 1'b0;
  endtask : refresh

  initial
  begin
    #40000;
    mismatches++;
    print_verdict();
  end

  initial
  begin
    {acc_req, acc_wr, cfg_load, cfg_fast_prog, cfg_fast_data} = '0;
    {cfg_dyn_en, cmd_req, hold_req, dma_drive, proc_reset_req} = '0;
    {refresh_req, fast_prog_mapped, fast_data_mapped, seen} = '0;
    {acc_addr, acc_wdata, cmd_word, dma_word} = '0;
    cfg_dyn_page     = 4'h0;
    acc_space        = etw_pkg::ETW_SP_PROG;
    clk_src          = etw_pkg::ETW_CS_CABLE;
    clk_variant_fast = 1'b1;
    clk_src_mhz      = 8'h28;
    step(4);
    nrst = 1'b1;
    step(1);
    chk(run_mode, 1'b1);
    repeat (20)
    begin
      step(1);
      chk(etw_bus_if_inst.emu_d_oe, 1'b0);
    end
    $display("reset test done");
    wr(etw_pkg::ETW_SP_PROG, 16'h8012, 16'h5a3c);
    rd(etw_pkg::ETW_SP_PROG, 16'h8012, 16'h5a3c, lf);
    wr(etw_pkg::ETW_SP_PROG, 16'h0034, 16'h1111);
    rd(etw_pkg::ETW_SP_PROG, 16'h0034, 16'h1111, ls);
    chk(ls - lf, 2);
    refresh();
    rd(etw_pkg::ETW_SP_PROG, 16'h8012, 16'h5a3c, lt);
    chk(lt > lf, 1'b1);
    $display("target test done");
    cfg(1'b1, 1'b0, 1'b0, 4'h0);
    wr(etw_pkg::ETW_SP_PROG, 16'h0034, 16'h2222);
    rd(etw_pkg::ETW_SP_PROG, 16'h0034, 16'h2222, lt);
    chk(lt, lf);
    refresh();
    rd(etw_pkg::ETW_SP_PROG, 16'h0034, 16'h2222, lt);
    chk(lt > lf, 1'b1);
    cfg(1'b0, 1'b1, 1'b0, 4'h0);
    wr(etw_pkg::ETW_SP_DATA, 16'h0034, 16'h3333);
    rd(etw_pkg::ETW_SP_DATA, 16'h0034, 16'h3333, lt);
    rd(etw_pkg::ETW_SP_PROG, 16'h0034, 16'h1111, lt);
    $display("fast memory test done");
    cfg(1'b0, 1'b0, 1'b1, 4'h1);
    wr(etw_pkg::ETW_SP_PROG, 16'h1040, 16'h7e81);
    n = cycle_count;
    rd(etw_pkg::ETW_SP_PROG, 16'h1040, 16'h7e81, ld);
    chk(cycle_count - n, 32'h7);
    chk(ld > ls, 1'b1);
    cfg(1'b0, 1'b0, 1'b0, 4'h0);
    $display("dynamic memory test done");
    cmd_word = 16'hc3a5;
    cmd_req  = 1'b1;
    step(1);
    cmd_req = 1'b0;
    // The halt pulse comes one edge after pending is set
    repeat (3)
    begin
      step(1);
      if (halt_irq === 1'b1)
        seen = 1'b1;
    end
    hold_req = 1'b1;
    n = 0;
    while (cmd_done !== 1'b1 && n < 40)
    begin
      if (halt_irq === 1'b1)
        seen = 1'b1;
      if (cmd_busy === 1'b1)
      begin
        chk(etw_bus_if_inst.data_bus, 16'hc3a5);
        chk(hold_granted, 1'b0);
      end
      step(1);
      n++;
    end
    chk(cmd_done, 1'b1);
    chk(seen, 1'b1);
    step(3);
    chk(hold_granted, 1'b1);
    dma_word  = 16'h0ff0;
    dma_drive = 1'b1;
    step(1);
    chk(etw_bus_if_inst.data_bus, 16'h0ff0);
    dma_drive = 1'b0;
    hold_req  = 1'b0;
    step(2);
    $display("command test done");
    proc_reset_req = 1'b1;
    step(1);
    chk(acc_ready, 1'b0);
    cmd_req = 1'b1;
    step(1);
    cmd_req = 1'b0;
    n = 0;
    while (sync_err !== 1'b1 && n < 1200)
    begin
      step(1);
      n++;
    end
    chk(sync_err, 1'b1);
    chk(err_code, 16'h0488);
    proc_reset_req = 1'b0;
    $display("sync loss test done");
    for (int i = 0; i < 8; i++)
    begin
      clk_src          = etw_pkg::etw_clk_src_t'(i[1:0]);
      clk_variant_fast = i[2];
      clk_src_mhz      = i[2] ? 8'h28 : 8'h14;
      step(2);
      chk(clk_cfg_ok, i[1:0] != 2'h3);
    end
    clk_src = etw_pkg::ETW_CS_CABLE;
    step(2);
    clk_src_mhz = 8'h14;
    step(2);
    chk(clk_cfg_ok, 1'b0);
    $display("clock source test done");
    print_verdict();
  end
endmodule : emulator_target_bus_wait_logic_tb
